// ---- logic/rsm_pkg.sv ----
/*
 * Package for the rotation speed measurement block: register offsets, field positions,
 * reset values, unit-time constants, counting modes, FSM states and carrier structs.
 * Assumes a 40 MHz pclk and one APB slave with 32-bit data and byte addresses.
 */
package rsm_pkg;

	// Register byte offsets on the APB.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_AVG    = 8'h04;
	localparam logic [7:0] ADDR_PPR    = 8'h08;
	localparam logic [7:0] ADDR_DEST   = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_SPEED  = 8'h14;
	localparam logic [7:0] ADDR_GPIO   = 8'h18;

	// Control register fields.
	localparam int CTRL_RUN_BIT  = 0;
	localparam int CTRL_UNIT_LSB = 1;
	localparam int CTRL_MODE_LSB = 4;
	// In-measurement flag position in the channel counter status word.
	localparam int STATUS_BUSY_BIT = 5;
	// General-purpose register: inputs read at bits 2:0, outputs written at bits 1:0.
	localparam int GPIO_IN_LSB  = 0;
	localparam int GPIO_OUT_LSB = 0;

	// Reset values.
	localparam logic [6:0]  CTRL_RST = 7'h00;
	localparam logic [6:0]  AVG_RST  = 7'h01;
	localparam logic [17:0] PPR_RST  = 18'h00001;
	localparam logic [31:0] DEST_RST = 32'h0000_0000;

	// Legal ranges and the minutes scale factor.
	localparam logic [6:0]  AVG_MIN   = 7'h01;
	localparam logic [6:0]  AVG_MAX   = 7'h64;
	localparam logic [17:0] PPR_MIN   = 18'h00001;
	localparam logic [17:0] PPR_MAX   = 18'h30D40;
	localparam int          RPM_SCALE = 60;

	// Unit times in milliseconds and the clock period in nanoseconds.
	localparam longint UNIT_T0_MS    = 10;
	localparam longint UNIT_T1_MS    = 100;
	localparam longint UNIT_T2_MS    = 1000;
	localparam longint CLK_PERIOD_NS = 25;
	localparam int unsigned CYC_T0 = int'((UNIT_T0_MS * 1000000) / CLK_PERIOD_NS);
	localparam int unsigned CYC_T1 = int'((UNIT_T1_MS * 1000000) / CLK_PERIOD_NS);
	localparam int unsigned CYC_T2 = int'((UNIT_T2_MS * 1000000) / CLK_PERIOD_NS);
	// Windows per second, the reciprocal of each unit time.
	localparam int RATE_T0 = int'(1000 / UNIT_T0_MS);
	localparam int RATE_T1 = int'(1000 / UNIT_T1_MS);
	localparam int RATE_T2 = int'(1000 / UNIT_T2_MS);
	// Shortest window that leaves room for both divisions.
	localparam int unsigned MIN_WIN_CYC = 128;
	localparam int DIV_W = 48;

	typedef enum logic [1:0] {
		UNIT_10MS  = 2'h0,
		UNIT_100MS = 2'h1,
		UNIT_1S    = 2'h2
	} rsm_unit_e;

	typedef enum logic [2:0] {
		MODE_1X1_A = 3'h0,
		MODE_1X2_A = 3'h1,
		MODE_1X1   = 3'h2,
		MODE_1X2   = 3'h3,
		MODE_CWCCW = 3'h4,
		MODE_2X1   = 3'h5,
		MODE_2X2   = 3'h6,
		MODE_2X4   = 3'h7
	} rsm_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT = 3'h1,
		ST_DIV1 = 3'h2,
		ST_AVG  = 3'h3,
		ST_DIV2 = 3'h4,
		ST_OUT  = 3'h5
	} rsm_state_e;

	typedef struct packed {
		rsm_mode_e   mode;
		rsm_unit_e   unit;
		logic [6:0]  avg;
		logic [17:0] ppr;
	} rsm_cfg_s;

	typedef struct packed {
		logic [31:0]        dest;
		logic signed [31:0] speed;
	} rsm_result_s;

endpackage : rsm_pkg

// ---- logic/rsm_pulse_decode.sv ----
/*
 * Pin synchroniser and pulse decoder: turns the encoder phases into one-cycle count pulses
 * and passes the spare pins on as clean levels.
 * Assumes asynchronous pins; each passes three flops and changes once flops two and three agree.
 */
`timescale 1ns/100ps
module rsm_pulse_decode
	import rsm_pkg::*;
#(
	parameter int NPIN = 5
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire rsm_mode_e       mode,
	input  wire logic [NPIN-1:0] pins,
	output logic                 up_q,
	output logic                 down_q,
	output logic [NPIN-1:0]      level_q
);

	logic [NPIN-1:0] s1_q;
	logic [NPIN-1:0] s2_q;
	logic [NPIN-1:0] s3_q;
	logic [1:0]      prev_q;

	if (NPIN < 2) begin : g_bad_npin
		$error("rsm_pulse_decode needs at least phase A and phase B");
	end

	// One synchroniser per pin; the agreement test filters a single metastable sample.
	for (genvar i = 0; i < NPIN; i++) begin : g_sync
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				s1_q[i]    <= 1'b0;
				s2_q[i]    <= 1'b0;
				s3_q[i]    <= 1'b0;
				level_q[i] <= 1'b0;
			end else begin
				s1_q[i] <= pins[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i]) begin
					level_q[i] <= s3_q[i];
				end
			end
		end
	end

	// Edge detection on the filtered phase levels.
	logic a;
	logic b;
	logic a_rise;
	logic a_edge;
	logic b_rise;
	logic b_edge;
	assign a      = level_q[0];
	assign b      = level_q[1];
	assign a_edge = a ^ prev_q[0];
	assign b_edge = b ^ prev_q[1];
	assign a_rise = a_edge & a;
	assign b_rise = b_edge & b;

	// Counting rules per mode; multiplied modes yield more edges per phase A cycle.
	logic up_d;
	logic down_d;
	always_comb begin
		up_d   = 1'b0;
		down_d = 1'b0;
		case (mode)
			MODE_1X1_A: up_d = a_rise;
			MODE_1X2_A: up_d = a_edge;
			MODE_1X1: begin
				up_d   = a_rise & ~b;
				down_d = a_rise & b;
			end
			MODE_1X2: begin
				up_d   = a_edge & ~b;
				down_d = a_edge & b;
			end
			MODE_CWCCW: begin
				up_d   = a_rise & ~b_rise;
				down_d = b_rise & ~a_rise;
			end
			MODE_2X1: begin
				up_d   = a_rise & ~b;
				down_d = a_rise & b;
			end
			MODE_2X2: begin
				up_d   = a_edge & (a ^ b);
				down_d = a_edge & ~(a ^ b);
			end
			MODE_2X4: begin
				// Simultaneous edges on both phases are illegal and dropped.
				up_d   = (a_edge & ~b_edge & (a ^ b)) | (b_edge & ~a_edge & ~(a ^ b));
				down_d = (a_edge & ~b_edge & ~(a ^ b)) | (b_edge & ~a_edge & (a ^ b));
			end
			default: begin
				up_d   = 1'b0;
				down_d = 1'b0;
			end
		endcase
	end

	// Registered pulses so the counter sees clean single-cycle strobes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 2'b00;
			up_q   <= 1'b0;
			down_q <= 1'b0;
		end else begin
			prev_q <= level_q[1:0];
			up_q   <= up_d;
			down_q <= down_d;
		end
	end

endmodule : rsm_pulse_decode

// ---- logic/rsm_speed_meas.sv ----
/*
 * Rotation speed measurement channel: APB register slave, unit-time window, pulse counter,
 * speed division with carried remainder, sliding average and result delivery.
 * Assumes an APB master on pclk and encoder pins asynchronous to pclk.
 */
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
module rsm_speed_meas
	import rsm_pkg::*;
#(
	parameter int          CNT_W     = 32,
	parameter int          AVG_DEPTH = 100,
	parameter int unsigned WIN_T0    = CYC_T0,
	parameter int unsigned WIN_T1    = CYC_T1,
	parameter int unsigned WIN_T2    = CYC_T2
) (
	input  wire logic  pclk,
	input  wire logic  presetn,
	input  wire logic  psel,
	input  wire logic  penable,
	input  wire logic  pwrite,
	input  wire logic  [7:0] paddr,
	input  wire logic  [31:0] pwdata,
	output logic       [31:0] prdata,
	output logic       pready,
	output logic       pslverr,
	input  wire logic  phase_a,
	input  wire logic  phase_b,
	input  wire logic  phase_z,
	input  wire logic  func_in,
	input  wire logic  latch_in,
	output logic       coin1_out,
	output logic       coin2_out,
	output logic       meas_busy,
	output logic       res_valid,
	output rsm_result_s res
);

	localparam int IDX_W = 7;
	localparam int SUM_W = CNT_W + IDX_W;
	localparam int DC_W  = $clog2(DIV_W + 1);

	// The history must hold the largest averaging count, or the mean reads past its end.
	if (CNT_W < 8 || CNT_W > 32 || AVG_DEPTH < AVG_MAX || AVG_DEPTH > 127) begin : g_bad_size
		$error("rsm_speed_meas: CNT_W must be 8..32 and AVG_DEPTH from AVG_MAX to 127");
	end
	if (WIN_T0 < MIN_WIN_CYC || WIN_T1 < MIN_WIN_CYC || WIN_T2 < MIN_WIN_CYC) begin : g_bad_win
		$error("rsm_speed_meas: unit windows are too short for the divider");
	end

	// Register file and control state.
	logic [6:0]         ctrl_q;
	logic [6:0]         avg_q;
	logic [17:0]        ppr_q;
	logic [31:0]        dest_q;
	logic [1:0]         gpo_q;
	logic               busy_q;
	rsm_cfg_s           cfg_q;
	rsm_state_e         st_q;
	logic [31:0]        win_q;
	logic signed [CNT_W-1:0] cnt_q;
	logic signed [CNT_W-1:0] cap_q;
	logic signed [31:0] speed_q;
	logic signed [31:0] newres_q;
	logic [17:0]        rem_q;
	logic               rem_neg_q;
	logic [IDX_W-1:0]   wr_idx_q;
	logic [IDX_W-1:0]   fill_q;
	logic signed [SUM_W-1:0] sum_q;
	logic [DIV_W-1:0]   dnum_q;
	logic [DIV_W-1:0]   drem_q;
	logic [DIV_W-1:0]   dden_q;
	logic [DC_W-1:0]    dcnt_q;
	logic               dneg_q;
	logic signed [CNT_W-1:0] avg_buf [AVG_DEPTH];

	// Pin decoding; spare pins are only mirrored into the GPIO register.
	logic       up_p;
	logic       down_p;
	logic [4:0] pin_lvl;
	rsm_pulse_decode #(
		.NPIN (5)
	) u_decode (
		.pclk    (pclk),
		.presetn (presetn),
		.mode    (cfg_q.mode),
		.pins    ({latch_in, func_in, phase_z, phase_b, phase_a}),
		.up_q    (up_p),
		.down_q  (down_p),
		.level_q (pin_lvl)
	);

	// APB decode: one wait state, writes land on the edge that samples pready high.
	logic        acc_start;
	logic        acc_done;
	logic        hit_ctrl;
	logic        hit_avg;
	logic        hit_ppr;
	logic        hit_dest;
	logic        hit_stat;
	logic        hit_speed;
	logic        hit_gpio;
	logic        mapped;
	logic [31:0] rd_data;
	assign acc_start = psel & penable & ~pready;
	assign acc_done  = psel & penable & pready;
	assign hit_ctrl  = (paddr == ADDR_CTRL);
	assign hit_avg   = (paddr == ADDR_AVG);
	assign hit_ppr   = (paddr == ADDR_PPR);
	assign hit_dest  = (paddr == ADDR_DEST);
	assign hit_stat  = (paddr == ADDR_STATUS);
	assign hit_speed = (paddr == ADDR_SPEED);
	assign hit_gpio  = (paddr == ADDR_GPIO);
	assign mapped    = hit_ctrl | hit_avg | hit_ppr | hit_dest | hit_stat | hit_speed | hit_gpio;
	assign rd_data   = hit_ctrl  ? {25'h0000000, ctrl_q} :
	                   hit_avg   ? {25'h0000000, avg_q} :
	                   hit_ppr   ? {14'h0000, ppr_q} :
	                   hit_dest  ? dest_q :
	                   hit_stat  ? (32'(busy_q) << STATUS_BUSY_BIT) :
	                   hit_speed ? speed_q :
	                   hit_gpio  ? {29'h00000000, pin_lvl[4:2]} : 32'h0000_0000;

	// Bus answer registers; an unmapped address answers with pslverr and zero data.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc_start;
			pslverr <= acc_start & ~mapped;
			prdata  <= (acc_start & ~pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	// Software-writable registers; status and speed are read-only.
	logic wr_en;
	assign wr_en = acc_done & pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
			avg_q  <= AVG_RST;
			ppr_q  <= PPR_RST;
			dest_q <= DEST_RST;
			gpo_q  <= 2'b00;
		end else if (wr_en) begin
			if (hit_ctrl) ctrl_q <= pwdata[6:0];
			if (hit_avg)  avg_q  <= pwdata[6:0];
			if (hit_ppr)  ppr_q  <= pwdata[17:0];
			if (hit_dest) dest_q <= pwdata;
			if (hit_gpio) gpo_q  <= pwdata[GPIO_OUT_LSB +: 2];
		end
	end

	// Clamped configuration, frozen at start so a running window never mixes settings.
	logic       run_cmd;
	logic       start;
	logic       stop;
	rsm_cfg_s   cfg_d;
	rsm_unit_e  unit_w;
	assign run_cmd    = ctrl_q[CTRL_RUN_BIT];
	assign start      = run_cmd & ~busy_q;
	assign stop       = ~run_cmd & busy_q;
	assign unit_w     = (ctrl_q[CTRL_UNIT_LSB +: 2] == 2'h3) ? UNIT_1S
	                  : rsm_unit_e'(ctrl_q[CTRL_UNIT_LSB +: 2]);
	assign cfg_d.mode = rsm_mode_e'(ctrl_q[CTRL_MODE_LSB +: 3]);
	assign cfg_d.unit = unit_w;
	assign cfg_d.avg  = (avg_q < AVG_MIN) ? AVG_MIN : (avg_q > AVG_MAX) ? AVG_MAX : avg_q;
	assign cfg_d.ppr  = (ppr_q < PPR_MIN) ? PPR_MIN : (ppr_q > PPR_MAX) ? PPR_MAX : ppr_q;

	// Window length and windows-per-second for the frozen unit time.
	logic [31:0] win_len;
	logic [6:0]  rate;
	logic        win_end;
	assign win_len = (cfg_q.unit == UNIT_10MS)  ? WIN_T0 :
	                 (cfg_q.unit == UNIT_100MS) ? WIN_T1 : WIN_T2;
	assign rate    = (cfg_q.unit == UNIT_10MS)  ? 7'(RATE_T0) :
	                 (cfg_q.unit == UNIT_100MS) ? 7'(RATE_T1) : 7'(RATE_T2);
	assign win_end = busy_q & (win_q == win_len - 32'h0000_0001);

	// Count for the closing window, including a pulse in its last cycle.
	logic signed [CNT_W-1:0] cnt_next;
	assign cnt_next = cnt_q + CNT_W'(up_p) - CNT_W'(down_p);

	// Numerator: |count| * 60 * windows-per-second plus the carried remainder when its sign matches the count's.
	logic              cap_neg;
	logic [CNT_W-1:0]  cap_mag;
	logic [DIV_W-1:0]  num_spd;
	logic [DIV_W-1:0]  carry;
	assign cap_neg = cnt_next[CNT_W-1];
	assign cap_mag = cap_neg ? CNT_W'(-cnt_next) : CNT_W'(cnt_next);
	assign carry   = (rem_neg_q == cap_neg) ? DIV_W'(rem_q) : DIV_W'(0);
	assign num_spd = DIV_W'(cap_mag) * DIV_W'(RPM_SCALE * rate) + carry;

	// Restoring divider step shared by the speed and the average divisions.
	logic [DIV_W-1:0] trial;
	logic             fits;
	assign trial = {drem_q[DIV_W-2:0], dnum_q[DIV_W-1]};
	assign fits  = (trial >= dden_q);
	logic signed [31:0] quo_s;
	assign quo_s = dneg_q ? -(32'(dnum_q)) : 32'(dnum_q);

	// Sliding-mean bookkeeping: the entry leaving the window sits N slots back.
	logic [IDX_W:0]     back_idx;
	logic [IDX_W-1:0]   old_idx;
	logic               full;
	logic signed [SUM_W-1:0] sum_d;
	logic [IDX_W-1:0]   wr_next;
	assign back_idx = {1'b0, wr_idx_q} + (IDX_W+1)'(AVG_DEPTH) - {1'b0, cfg_q.avg};
	assign old_idx  = (wr_idx_q >= cfg_q.avg) ? (wr_idx_q - cfg_q.avg) : back_idx[IDX_W-1:0];
	assign full     = (fill_q >= cfg_q.avg);
	assign sum_d    = sum_q + SUM_W'(newres_q) - (full ? SUM_W'(avg_buf[old_idx]) : SUM_W'(0));
	assign wr_next  = (wr_idx_q == IDX_W'(AVG_DEPTH - 1)) ? '0 : wr_idx_q + 1'b1;

	// Window timer and pulse counter; both restart when measurement starts.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_q <= 32'h0000_0000;
			cnt_q <= '0;
		end else if (!busy_q || win_end) begin
			win_q <= 32'h0000_0000;
			cnt_q <= '0;
		end else begin
			win_q <= win_q + 32'h0000_0001;
			cnt_q <= cnt_next;
		end
	end

	// History of per-window results; no reset needed since fill_q guards reads.
	always_ff @(posedge pclk) begin
		if (st_q == ST_AVG) begin
			avg_buf[wr_idx_q] <= CNT_W'(newres_q);
		end
	end

	// Measurement sequencer: wait for a window, divide, average, deliver.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= ST_IDLE;
			busy_q    <= 1'b0;
			cfg_q     <= '{mode: MODE_1X1_A, unit: UNIT_10MS, avg: AVG_RST, ppr: PPR_RST};
			cap_q     <= '0;
			speed_q   <= 32'sh0000_0000;
			newres_q  <= 32'sh0000_0000;
			rem_q     <= 18'h00000;
			rem_neg_q <= 1'b0;
			wr_idx_q  <= '0;
			fill_q    <= '0;
			sum_q     <= '0;
			dnum_q    <= '0;
			drem_q    <= '0;
			dden_q    <= '0;
			dcnt_q    <= '0;
			dneg_q    <= 1'b0;
			res_valid <= 1'b0;
			res       <= '0;
		end else begin
			res_valid <= 1'b0;
			if (stop) begin
				// Stopping drops the pending window and zeroes the speed.
				st_q      <= ST_IDLE;
				busy_q    <= 1'b0;
				speed_q   <= 32'sh0000_0000;
				rem_q     <= 18'h00000;
				rem_neg_q <= 1'b0;
				fill_q    <= '0;
				wr_idx_q  <= '0;
				sum_q     <= '0;
			end else begin
				case (st_q)
					ST_IDLE: begin
						if (start) begin
							busy_q <= 1'b1;
							cfg_q  <= cfg_d;
							st_q   <= ST_WAIT;
						end
					end
					ST_WAIT: begin
						if (win_end) begin
							cap_q <= cnt_next;
							if (cnt_next == '0) begin
								// An empty window reports zero and drops the carry.
								newres_q <= 32'sh0000_0000;
								rem_q    <= 18'h00000;
								st_q     <= ST_AVG;
							end else begin
								dnum_q <= num_spd;
								drem_q <= '0;
								dden_q <= DIV_W'(cfg_q.ppr);
								dcnt_q <= DC_W'(DIV_W);
								dneg_q <= cap_neg;
								st_q   <= ST_DIV1;
							end
						end
					end
					ST_DIV1, ST_DIV2: begin
						if (dcnt_q != '0) begin
							drem_q <= fits ? trial - dden_q : trial;
							dnum_q <= {dnum_q[DIV_W-2:0], fits};
							dcnt_q <= dcnt_q - 1'b1;
						end else if (st_q == ST_DIV1) begin
							newres_q  <= quo_s;
							rem_q     <= 18'(drem_q);
							rem_neg_q <= dneg_q;
							st_q      <= ST_AVG;
						end else begin
							speed_q <= quo_s;
							st_q    <= ST_OUT;
						end
					end
					ST_AVG: begin
						sum_q    <= sum_d;
						wr_idx_q <= wr_next;
						if (!full) begin
							fill_q <= fill_q + 1'b1;
						end
						if (cfg_q.avg == AVG_MIN) begin
							speed_q <= newres_q;
							st_q    <= ST_OUT;
						end else if (fill_q + 1'b1 < cfg_q.avg) begin
							st_q <= ST_WAIT;
						end else begin
							dnum_q <= sum_d[SUM_W-1] ? DIV_W'(-sum_d) : DIV_W'(sum_d);
							drem_q <= '0;
							dden_q <= DIV_W'(cfg_q.avg);
							dcnt_q <= DC_W'(DIV_W);
							dneg_q <= sum_d[SUM_W-1];
							st_q   <= ST_DIV2;
						end
					end
					ST_OUT: begin
						res_valid  <= 1'b1;
						res.dest   <= dest_q;
						res.speed  <= speed_q;
						st_q       <= ST_WAIT;
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// Spare outputs and the status mirror, all registered.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			coin1_out <= 1'b0;
			coin2_out <= 1'b0;
			meas_busy <= 1'b0;
		end else begin
			coin1_out <= gpo_q[0];
			coin2_out <= gpo_q[1];
			meas_busy <= busy_q;
		end
	end

endmodule : rsm_speed_meas

// ---- dv/rsm_speed_meas_chk.sv ----
/* Concurrent checks on the ports of rsm_speed_meas: APB handshake, result pulse, run flag
   and the spare output coin1_out. Assumes one pclk domain with presetn as its asynchronous reset. */
`timescale 1ns/100ps
module rsm_speed_meas_chk
	import rsm_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        coin1_out,
	input wire logic        meas_busy,
	input wire logic        res_valid
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// A completed control write, and a quiet spell of eight cycles with no result.
	sequence s_wr_ctrl;
		pready && psel && pwrite && paddr == ADDR_CTRL;
	endsequence
	sequence s_quiet;
		!res_valid [*8];
	endsequence

	a_apb_answer: assert property (psel && penable && !pready |=> pready)
		else $error("pready missing after first access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("pready without an access phase");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside the answer cycle");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data driven outside the answer cycle");
	a_valid_pulse: assert property (res_valid |=> !res_valid)
		else $error("result strobe longer than one cycle");
	a_start_busy: assert property (s_wr_ctrl ##0 pwdata[0] |-> ##[1:4] meas_busy)
		else $error("busy flag did not rise after start");
	a_stop_idle: assert property (s_wr_ctrl ##0 !pwdata[0] |-> ##[1:4] !meas_busy)
		else $error("busy flag did not fall after stop");
	a_first_quiet: assert property ($rose(meas_busy) |-> s_quiet)
		else $error("result before the first window could end");
	a_coin_write: assert property ($changed(coin1_out) |->
		$past(pready && pwrite && paddr == ADDR_GPIO, 2))
		else $error("spare output moved without a register write");
endmodule : rsm_speed_meas_chk

bind rsm_speed_meas rsm_speed_meas_chk u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.coin1_out(coin1_out), .meas_busy(meas_busy), .res_valid(res_valid)
);

// ---- dv/rsm_enc_model.sv ----
/* Quadrature encoder model driving phase A and B with one state step every STEP cycles.
   Assumes the bench enables it and picks the direction while measurement is stopped. */
`timescale 1ns/100ps
module rsm_enc_model #(
	parameter int STEP = 10
) (
	input  wire logic pclk,
	input  wire logic en,
	input  wire logic dir,
	output logic      phase_a,
	output logic      phase_b
);
	int         cnt = 0;
	logic [1:0] s   = 2'h0;

	// A steady step keeps every window's count exact; only the 18'h11170 run carries a remainder into its judged result.
	always @(posedge pclk) begin
		cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
		if (en && cnt == STEP - 1) begin
			s <= dir ? s - 2'h1 : s + 2'h1;
		end
	end
	// Gray order; phase A leads when counting up.
	assign phase_a = s[0] ^ s[1];
	assign phase_b = s[1];
endmodule : rsm_enc_model

// ---- dv/tb.sv ----
/* Self-checking bench for rsm_speed_meas with the encoder model on its phase inputs.
   Assumes windows shortened to 200, 400 and 800 cycles. */
`timescale 1ns/100ps
module tb;
	import rsm_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        phase_a, phase_b, phase_z, func_in, latch_in, enc_en, enc_dir;
	logic        coin1_out, coin2_out, meas_busy, res_valid;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	rsm_result_s res, r;
	int          err_count = 0;
	int          checked = 0;
	int          cyc = 0;
	int          t0;

	rsm_speed_meas #(.WIN_T0(200), .WIN_T1(400), .WIN_T2(800)) u_rsm_speed_meas (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.phase_a(phase_a), .phase_b(phase_b), .phase_z(phase_z), .func_in(func_in),
		.latch_in(latch_in), .coin1_out(coin1_out), .coin2_out(coin2_out),
		.meas_busy(meas_busy), .res_valid(res_valid), .res(res)
	);
	rsm_enc_model u_rsm_enc_model (
		.pclk(pclk), .en(enc_en), .dir(enc_dir), .phase_a(phase_a), .phase_b(phase_b)
	);

	// Clock, plus a watchdog that ends a hung run.
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			$display("unexpected %0t watchdog expired", $time);
			end_of_test();
		end
	end

	task end_of_test;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; the request stands until pready is sampled high.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task next_res;
		do @(posedge pclk); while (res_valid !== 1'b1);
		r = res;
	endtask : next_res

	// Run one measurement; the second result is judged, as the first may hold a pulse decoded under the previous mode.
	task meas(input logic [2:0] m, input logic [1:0] u, input logic [6:0] n,
		input logic [17:0] p, input logic [31:0] exp);
		apb(1'b1, ADDR_AVG, {25'h0, n});
		apb(1'b1, ADDR_PPR, {14'h0, p});
		apb(1'b1, ADDR_DEST, {14'h2A5, p});
		apb(1'b1, ADDR_CTRL, 32'(m) << CTRL_MODE_LSB | 32'(u) << CTRL_UNIT_LSB | 32'h1);
		t0 = cyc;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & 32'h20, 32'h20);
		next_res();
		chk(32'(cyc - t0 >= n * (200 << u)), 32'h1);
		chk(32'(cyc - t0 < (n + 1) * (200 << u)), 32'h1);
		next_res();
		chk(r.speed, exp);
		chk(r.dest, {14'h2A5, p});
		apb(1'b0, ADDR_SPEED, 32'h0);
		chk(rd, exp);
		apb(1'b1, ADDR_CTRL, 32'h0);
		repeat (4) @(posedge pclk);
		chk({31'h0, meas_busy}, 32'h0);
		apb(1'b0, ADDR_SPEED, 32'h0);
		chk(rd, 32'h0);
	endtask : meas

	task t_regs;
		apb(1'b0, ADDR_AVG, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, ADDR_PPR, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, ADDR_SPEED, 32'h55);
		apb(1'b0, ADDR_SPEED, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h1C, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("t_regs done");
	endtask : t_regs

	task t_gpio;
		apb(1'b1, ADDR_GPIO, 32'h2);
		repeat (2) @(posedge pclk);
		chk({30'h0, coin2_out, coin1_out}, 32'h2);
		apb(1'b1, ADDR_GPIO, 32'h1);
		repeat (2) @(posedge pclk);
		chk({30'h0, coin2_out, coin1_out}, 32'h1);
		apb(1'b0, ADDR_GPIO, 32'h0);
		chk(rd & 32'h7, 32'h5);
		phase_z <= 1'b0;
		repeat (6) @(posedge pclk);
		apb(1'b0, ADDR_GPIO, 32'h0);
		chk(rd & 32'h7, 32'h4);
		$display("t_gpio done");
	endtask : t_gpio

	// Edge every 10 cycles: 20 edges per 200-cycle window in times-4 mode.
	task t_speed;
		enc_en <= 1'b1;
		meas(MODE_2X4, UNIT_10MS, 7'h01, 18'h01770, 32'h14);
		meas(MODE_2X2, UNIT_10MS, 7'h01, 18'h01770, 32'hA);
		meas(MODE_2X1, UNIT_10MS, 7'h01, 18'h01770, 32'h5);
		meas(MODE_1X1_A, UNIT_10MS, 7'h01, 18'h01770, 32'h5);
		meas(MODE_1X2_A, UNIT_10MS, 7'h01, 18'h01770, 32'hA);
		meas(MODE_2X4, UNIT_10MS, 7'h01, 18'h11170, 32'h2);
		meas(MODE_2X4, UNIT_100MS, 7'h01, 18'h00258, 32'h28);
		meas(MODE_2X4, UNIT_1S, 7'h01, 18'h0003C, 32'h50);
		meas(MODE_2X4, UNIT_10MS, 7'h04, 18'h01770, 32'h14);
		enc_dir <= 1'b1;
		meas(MODE_2X4, UNIT_10MS, 7'h01, 18'h01770, 32'hFFFF_FFEC);
		meas(MODE_1X1, UNIT_10MS, 7'h01, 18'h01770, 32'hFFFF_FFFB);
		enc_en <= 1'b0;
		meas(MODE_2X4, UNIT_10MS, 7'h01, 18'h01770, 32'h0);
		$display("t_speed done");
	endtask : t_speed

	// Reset, then the scenarios in turn.
	initial begin
		presetn  = 1'b0;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = 8'h00;
		pwdata   = 32'h0;
		phase_z  = 1'b1;
		func_in  = 1'b0;
		latch_in = 1'b1;
		enc_en   = 1'b0;
		enc_dir  = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_gpio();
		t_speed();
		end_of_test();
	end
endmodule : tb
